/* afe_ctrl_pkg.sv */
package afe_ctrl_pkg;
    // ****************************************
    // command format
    // ****************************************
    localparam int ADDR_W = 10;  // address bits per command
    localparam int DATA_W = 6;   // data bits per group
    localparam int HDR_BITS = 16;  // address plus first data group
    localparam int NREG = 14;    // implemented registers
    localparam int WORD_W = ADDR_W + DATA_W + 1;  // first flag, address, data

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [9:0] IDX_POLARITY = 10'h000;  // pulse_polarity_update_ctrl
    localparam logic [9:0] IDX_STANDBY  = 10'h001;  // standby_ctrl
    localparam logic [9:0] IDX_OUTPUT   = 10'h002;  // output_ctrl
    localparam logic [9:0] IDX_SDELAY   = 10'h003;  // sample_delay
    localparam logic [9:0] IDX_CLAMP    = 10'h004;  // black_clamp_level
    localparam logic [9:0] IDX_DEFECT   = 10'h005;  // defect_reject_level
    localparam logic [9:0] IDX_DGAIN_LO = 10'h006;  // digital_gain_low
    localparam logic [9:0] IDX_DGAIN_HI = 10'h007;  // digital_gain_high
    localparam logic [9:0] IDX_AGAIN    = 10'h008;  // analog_gain
    localparam logic [9:0] IDX_POWER    = 10'h009;  // power_trim
    localparam logic [9:0] IDX_DAC1_LO  = 10'h00a;  // first_dac_code_low
    localparam logic [9:0] IDX_DAC1_HI  = 10'h00b;  // first_dac_code_high
    localparam logic [9:0] IDX_DAC2_LO  = 10'h00c;  // second_dac_code_low
    localparam logic [9:0] IDX_DAC2_HI  = 10'h00d;  // second_dac_code_high

    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_UPD_BY_STROBE = 1;  // polarity reg: update mode
    localparam int POS_COMMIT_FALL   = 2;  // polarity reg: commit edge
    localparam int POS_DUMMY_POL     = 3;  // polarity reg: dummy clamp level
    localparam int POS_BLACK_POL     = 4;  // polarity reg: black clamp level
    localparam int POS_SAMPLE_POL    = 5;  // polarity reg: sample pulse level
    localparam int POS_STANDBY       = 0;  // standby reg
    localparam int POS_DAC1_STBY     = 1;
    localparam int POS_DAC2_STBY     = 2;
    localparam int POS_TEST_EN       = 3;
    localparam int POS_HIZ           = 4;  // output reg: high impedance

    // ****************************************
    // storable bits and reset values, highest index first
    // ****************************************
    localparam logic [NREG-1:0][5:0] WR_MASK = {
        6'h07, 6'h3f, 6'h07, 6'h3f, 6'h3f, 6'h0f, 6'h1f,
        6'h3f, 6'h3f, 6'h3f, 6'h07, 6'h17, 6'h1f, 6'h3e};
    localparam logic [NREG-1:0][5:0] RST_VAL = {
        6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h03,
        6'h00, 6'h3f, 6'h08, 6'h00, 6'h00, 6'h06, 6'h00};
endpackage : afe_ctrl_pkg

/* serial_cmd_shifter.sv */
`timescale 1ns/1ps
module serial_cmd_shifter
    import afe_ctrl_pkg::*;
(
    input  wire logic                       i_sclk,                 // link clock
    input  wire logic                       i_reset,                // async, high
    input  wire logic                       i_serial_in,            // serial data
    input  wire logic                       i_serial_latch_strobe,  // low while writing
    output logic     [afe_ctrl_pkg::WORD_W-1:0] o_word,             // first, addr, data
    output logic                            o_word_toggle           // flips per group
);
    import afe_ctrl_pkg::*;

    // ****************************************
    // frame state, cleared while the strobe is high
    // ****************************************
    logic            frame_rst;  // strobe high ends the frame
    logic [4:0]      cnt_reg, cnt_next;      // header bit count
    logic [2:0]      grp_reg, grp_next;      // continuation bit count
    logic [9:0]      addr_reg, addr_next;    // current address
    logic [5:0]      dat_reg, dat_next;      // data group being shifted
    logic [WORD_W-1:0] word_reg, word_next;  // last complete group
    logic            tog_reg, tog_next;
    logic            done;                   // group completes this edge

    // the clock may stop between frames, so the strobe itself clears the count
    assign frame_rst = i_reset | i_serial_latch_strobe;

    always_comb begin
        cnt_next  = cnt_reg;
        grp_next  = grp_reg;
        addr_next = addr_reg;
        dat_next  = dat_reg;
        word_next = word_reg;
        tog_next  = tog_reg;
        done      = 1'b0;
        if (cnt_reg < 5'(ADDR_W)) begin  // address, lsb first
            addr_next[cnt_reg[3:0]] = i_serial_in;
            cnt_next = cnt_reg + 5'h01;
        end else if (cnt_reg < 5'(HDR_BITS)) begin
            dat_next[3'(cnt_reg - 5'(ADDR_W))] = i_serial_in;
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'(HDR_BITS - 1)) begin
                done = 1'b1;
                word_next = {1'b1, addr_reg, i_serial_in, dat_reg[4:0]};
            end
        end else begin  // continuous mode: next address per group
            dat_next[grp_reg] = i_serial_in;
            grp_next = (grp_reg == 3'h5) ? 3'h0 : grp_reg + 3'h1;
            if (grp_reg == 3'h5) begin
                done = 1'b1;
                addr_next = addr_reg + 10'h001;
                word_next = {1'b0, addr_reg + 10'h001, i_serial_in, dat_reg[4:0]};
            end
        end
        if (done) begin
            tog_next = ~tog_reg;
        end
    end

    // counters follow the frame
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_reg  <= 5'h00;
            grp_reg  <= 3'h0;
            addr_reg <= 10'h000;
            dat_reg  <= 6'h00;
        end else begin
            cnt_reg  <= cnt_next;
            grp_reg  <= grp_next;
            addr_reg <= addr_next;
            dat_reg  <= dat_next;
        end
    end

    // word and toggle survive the end of frame for the other domain
    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            word_reg <= '0;
            tog_reg  <= 1'b0;
        end else begin
            word_reg <= word_next;
            tog_reg  <= tog_next;
        end
    end

    assign o_word        = word_reg;
    assign o_word_toggle = tog_reg;

    header_done_a: assert property (@(posedge i_sclk) disable iff (frame_rst)
        cnt_reg == 5'(HDR_BITS - 1) |=> tog_reg != $past(tog_reg) && word_reg[WORD_W-1])
        else $error("header group not published");
    cont_group_a: assert property (@(posedge i_sclk) disable iff (frame_rst)
        grp_reg == 3'h5 |=> !word_reg[WORD_W-1] && word_reg[15:6] == $past(addr_reg) + 10'h001)
        else $error("continuation group address wrong");
endmodule : serial_cmd_shifter

/* afe_serial_control_regs.sv */
`timescale 1ns/1ps
// Operation
// - ten address bits then six data bits
// - polarity bit 1 selects buffered update
// - polarity bit 2 selects commit edge
// - falling-edge select always forces buffered update
// - bits 3..5 set clamp and sample levels
// - standby bit places device in standby
// - dac standbys default set, test off
// - output delay code 0..6 ns
// - output enable bit drives hi-z
// - sample delay code, upper codes forbidden
// - clamp level code, default 01000
// - serial bits shift on link clock rise
// - continuation groups go to next address
// - buffered data commit together on strobe
module afe_serial_control_regs
    import afe_ctrl_pkg::*;
(
    input  wire logic       I_CLK,                      // system clock, 25 MHz
    input  wire logic       I_RESET,                    // async, high
    input  wire logic       I_SCLK,                     // serial link clock
    input  wire logic       I_SERIAL_IN,                // serial data
    input  wire logic       I_SERIAL_LATCH_STROBE,      // low while writing
    input  wire logic       I_REGISTER_COMMIT_STROBE,   // commits buffered data
    output logic            O_UPDATE_BY_STROBE,         // updates gated by commit
    output logic            O_COMMIT_ON_FALL,           // commit edge select
    output logic            O_DUMMY_CLAMP_ACTIVE_HIGH,  // dummy_clamp_pulse level
    output logic            O_BLACK_CLAMP_ACTIVE_HIGH,  // black_clamp_pulse level
    output logic            O_SAMPLE_ACTIVE_HIGH,       // sample pulses level
    output logic            O_STANDBY,                  // whole device standby
    output logic            O_DAC1_STANDBY,             // first dac standby
    output logic            O_DAC2_STANDBY,             // second dac standby
    output logic            O_TEST_ENABLE,              // test mode
    output logic [1:0]      O_OUTPUT_DELAY,             // 0/2/4/6 ns code
    output logic            O_OUTPUT_HIZ,               // data outputs high-z
    output logic [1:0]      O_SAMPLE_DELAY,             // data sample delay code
    output logic            O_SAMPLE_DELAY_INVALID,     // forbidden code held
    output logic [4:0]      O_CLAMP_CODE,               // black clamp level code
    output logic [5:0]      O_DEFECT_REJECT_LEVEL,      // defect reject register
    output logic [9:0]      O_DIGITAL_GAIN,             // combined digital gain
    output logic [3:0]      O_ANALOG_GAIN,              // analog gain register
    output logic [5:0]      O_POWER_TRIM,               // power register
    output logic [7:0]      O_FIRST_DAC_CODE,           // first dac code
    output logic [7:0]      O_SECOND_DAC_CODE           // second dac code
);
    import afe_ctrl_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    // true for the fourteen implemented addresses
    function automatic logic addr_ok(input logic [9:0] a);
        addr_ok = (a < 10'(NREG));
    endfunction : addr_ok

    // ****************************************
    // link side
    // ****************************************
    logic [WORD_W-1:0] link_word;  // stable for six link clocks after toggle
    logic              link_tog;   // flips once per complete group

    serial_cmd_shifter u_shifter (
        .i_sclk                (I_SCLK),
        .i_reset               (I_RESET),
        .i_serial_in           (I_SERIAL_IN),
        .i_serial_latch_strobe (I_SERIAL_LATCH_STROBE),
        .o_word                (link_word),
        .o_word_toggle         (link_tog)
    );

    // ****************************************
    // synchronisers into the system clock
    // ****************************************
    logic [2:0] tog_sync_reg, tog_sync_next;      // toggle, 2ff plus history
    logic [2:0] latch_sync_reg, latch_sync_next;  // serial strobe
    logic [2:0] commit_sync_reg, commit_sync_next;  // commit strobe
    logic       tog_edge;     // a group has arrived
    logic       latch_rise;   // write frame ended
    logic       commit_rise;  // commit strobe rising
    logic       commit_fall;  // commit strobe falling

    always_comb begin
        tog_sync_next    = {tog_sync_reg[1:0], link_tog};
        latch_sync_next  = {latch_sync_reg[1:0], I_SERIAL_LATCH_STROBE};
        commit_sync_next = {commit_sync_reg[1:0], I_REGISTER_COMMIT_STROBE};
    end

    // stage 0 is only read by stage 1
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            tog_sync_reg    <= 3'h0;
            latch_sync_reg  <= 3'h7;  // idle strobe is high
            commit_sync_reg <= 3'h0;
        end else begin
            tog_sync_reg    <= tog_sync_next;
            latch_sync_reg  <= latch_sync_next;
            commit_sync_reg <= commit_sync_next;
        end
    end

    assign tog_edge    = tog_sync_reg[2] ^ tog_sync_reg[1];
    assign latch_rise  = latch_sync_reg[1] & ~latch_sync_reg[2];
    assign commit_rise = commit_sync_reg[1] & ~commit_sync_reg[2];
    assign commit_fall = ~commit_sync_reg[1] & commit_sync_reg[2];

    // ****************************************
    // command sequencing
    // ****************************************
    // the first group waits for the end of the frame; later groups land
    // at once. word is sampled late enough that the link side holds it
    logic [WORD_W-1:0] pend_reg, pend_next;  // first group awaiting latch
    logic              pend_vld_reg, pend_vld_next;
    logic              go_reg, go_next;      // latch seen, fire pending
    logic              cont_fire;            // continuation group now
    logic              pend_fire;            // first group now
    logic              wr_fire;              // a valid write this cycle
    logic [9:0]        wr_addr;
    logic [5:0]        wr_data;

    always_comb begin
        cont_fire = tog_edge & ~link_word[WORD_W-1];
        pend_fire = pend_vld_reg & (go_reg | latch_rise) & ~cont_fire;
        pend_next = pend_reg;
        pend_vld_next = pend_vld_reg;
        if (pend_fire) begin
            pend_vld_next = 1'b0;
        end
        if (tog_edge && link_word[WORD_W-1]) begin  // new header group
            pend_next = link_word;
            pend_vld_next = 1'b1;
        end
        // go only lives while the strobe stays high
        go_next = latch_sync_reg[1] ? ((go_reg | latch_rise) & ~pend_fire) : 1'b0;
        if (cont_fire) begin
            wr_addr = link_word[15:6];
            wr_data = link_word[5:0];
        end else begin
            wr_addr = pend_reg[15:6];
            wr_data = pend_reg[5:0];
        end
        wr_fire = (cont_fire | pend_fire) & addr_ok(wr_addr);
    end

    // sequencing state
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pend_reg     <= '0;
            pend_vld_reg <= 1'b0;
            go_reg       <= 1'b0;
        end else begin
            pend_reg     <= pend_next;
            pend_vld_reg <= pend_vld_next;
            go_reg       <= go_next;
        end
    end

    // ****************************************
    // buffer and active registers
    // ****************************************
    logic [NREG-1:0][5:0] buf_reg, buf_next;  // written, not yet committed
    logic [NREG-1:0][5:0] act_reg, act_next;  // values in force
    logic                 gated;              // updates wait for commit
    logic                 commit_fire;        // selected commit edge seen
    logic [3:0]           wr_idx;

    always_comb begin
        // falling-edge select implies gating whatever the mode bit says
        gated = act_reg[IDX_POLARITY][POS_UPD_BY_STROBE] |
                act_reg[IDX_POLARITY][POS_COMMIT_FALL];
        commit_fire = act_reg[IDX_POLARITY][POS_COMMIT_FALL] ?
                      commit_fall : commit_rise;
        wr_idx   = wr_addr[3:0];
        buf_next = buf_reg;
        act_next = act_reg;
        if (commit_fire && gated) begin
            act_next = buf_reg;
        end
        if (wr_fire) begin
            buf_next[wr_idx] = wr_data & WR_MASK[wr_idx];
            if (!gated) begin
                act_next[wr_idx] = wr_data & WR_MASK[wr_idx];
            end
        end
    end

    // reset loads every default; nothing depends on a first write
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            buf_reg <= RST_VAL;
            act_reg <= RST_VAL;
        end else begin
            buf_reg <= buf_next;
            act_reg <= act_next;
        end
    end

    // ****************************************
    // control fields
    // ****************************************
    // all straight from flip-flops, so no decode glitches reach the pins
    assign O_UPDATE_BY_STROBE        = act_reg[IDX_POLARITY][POS_UPD_BY_STROBE];
    assign O_COMMIT_ON_FALL          = act_reg[IDX_POLARITY][POS_COMMIT_FALL];
    assign O_DUMMY_CLAMP_ACTIVE_HIGH = act_reg[IDX_POLARITY][POS_DUMMY_POL];
    assign O_BLACK_CLAMP_ACTIVE_HIGH = act_reg[IDX_POLARITY][POS_BLACK_POL];
    assign O_SAMPLE_ACTIVE_HIGH      = act_reg[IDX_POLARITY][POS_SAMPLE_POL];
    assign O_STANDBY                 = act_reg[IDX_STANDBY][POS_STANDBY];
    assign O_DAC1_STANDBY            = act_reg[IDX_STANDBY][POS_DAC1_STBY];
    assign O_DAC2_STANDBY            = act_reg[IDX_STANDBY][POS_DAC2_STBY];
    assign O_TEST_ENABLE             = act_reg[IDX_STANDBY][POS_TEST_EN];
    assign O_OUTPUT_DELAY            = act_reg[IDX_OUTPUT][1:0];
    assign O_OUTPUT_HIZ              = act_reg[IDX_OUTPUT][POS_HIZ];
    assign O_SAMPLE_DELAY            = act_reg[IDX_SDELAY][1:0];
    // forbidden codes are stored as written and only flagged
    assign O_SAMPLE_DELAY_INVALID    = act_reg[IDX_SDELAY][1];
    assign O_CLAMP_CODE              = act_reg[IDX_CLAMP][4:0];
    assign O_DEFECT_REJECT_LEVEL     = act_reg[IDX_DEFECT];
    assign O_DIGITAL_GAIN            = {act_reg[IDX_DGAIN_HI][3:0], act_reg[IDX_DGAIN_LO]};
    assign O_ANALOG_GAIN             = act_reg[IDX_AGAIN][3:0];
    assign O_POWER_TRIM              = act_reg[IDX_POWER];
    assign O_FIRST_DAC_CODE          = {act_reg[IDX_DAC1_HI][1:0], act_reg[IDX_DAC1_LO]};
    assign O_SECOND_DAC_CODE         = {act_reg[IDX_DAC2_HI][1:0], act_reg[IDX_DAC2_LO]};

    // ****************************************
    // checks
    // ****************************************
    realtime_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        wr_fire && !gated |=> act_reg[$past(wr_idx)] == ($past(wr_data) & WR_MASK[$past(wr_idx)]))
        else $error("real-time write not applied");
    gated_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        act_reg[IDX_POLARITY][POS_COMMIT_FALL] && !commit_fall |=> $stable(act_reg))
        else $error("active register moved without commit");
    commit_edge_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !act_reg[IDX_POLARITY][POS_COMMIT_FALL] && gated && commit_rise
        |=> act_reg[IDX_CLAMP] == $past(buf_reg[IDX_CLAMP]))
        else $error("rising commit did not copy buffer");
    commit_all_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        commit_fire && gated |=> act_reg == $past(buf_reg))
        else $error("commit did not move all registers");
    reserved_drop_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (cont_fire || pend_fire) && !addr_ok(wr_addr) && !(commit_fire && gated)
        |=> $stable(act_reg) && $stable(buf_reg))
        else $error("reserved address changed a register");
    fixed_zero_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        wr_fire |=> !act_reg[IDX_POLARITY][0] && !act_reg[IDX_STANDBY][5])
        else $error("fixed zero bit stored");
    // the latch edge may follow the header toggle by a single cycle, so the
    // pending flag is only required to hold while the synced strobe is low
    first_waits_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (tog_edge && link_word[WORD_W-1]) || (pend_vld_reg && !latch_sync_reg[1])
        |=> pend_vld_reg)
        else $error("header group applied before latch");
    reset_defaults_a: assert property (@(posedge I_CLK)
        I_RESET |=> O_DAC1_STANDBY && O_DAC2_STANDBY && O_CLAMP_CODE == 5'h08 && !O_STANDBY)
        else $error("defaults not restored by reset");
endmodule : afe_serial_control_regs

/* serial_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// serial controller model, link clock 30 ns
// ****************************************
module serial_host_model (
    output logic o_sclk,                // link clock, still between frames
    output logic o_serial_in,           // serial data
    output logic o_serial_latch_strobe  // low for the whole frame
);
    initial begin
        o_sclk = 1'b0;
        o_serial_in = 1'b0;
        o_serial_latch_strobe = 1'b1;
    end
    // data set while the clock is low, taken by the device on the rise
    task automatic put_bit(input logic b);
        o_serial_in = b;
        #15 o_sclk = 1'b1;
        #15 o_sclk = 1'b0;
    endtask : put_bit
    // address then groups, all lsb first; tail adds an incomplete group
    task automatic send(input logic [9:0] addr, input logic [47:0] grp,
                        input int ngrp, input int tail);
        int i;
        o_serial_latch_strobe = 1'b0;
        #20;
        for (i = 0; i < 10; i++) put_bit(addr[i]);
        for (i = 0; i < 6 * ngrp; i++) put_bit(grp[i]);
        for (i = 0; i < tail; i++) put_bit(1'b1);
        #20;
        o_serial_latch_strobe = 1'b1;
        // released line shows no stale value
        o_serial_in = ~o_serial_in;
    endtask : send
endmodule : serial_host_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import afe_ctrl_pkg::*;
    logic I_CLK, I_RESET, I_REGISTER_COMMIT_STROBE;      // bench-driven
    wire logic I_SCLK, I_SERIAL_IN, I_SERIAL_LATCH_STROBE; // from host model
    logic O_UPDATE_BY_STROBE, O_COMMIT_ON_FALL, O_DUMMY_CLAMP_ACTIVE_HIGH;
    logic O_BLACK_CLAMP_ACTIVE_HIGH, O_SAMPLE_ACTIVE_HIGH, O_STANDBY;
    logic O_DAC1_STANDBY, O_DAC2_STANDBY, O_TEST_ENABLE, O_OUTPUT_HIZ;
    logic O_SAMPLE_DELAY_INVALID;
    logic [1:0] O_OUTPUT_DELAY, O_SAMPLE_DELAY;
    logic [4:0] O_CLAMP_CODE;
    logic [5:0] O_DEFECT_REJECT_LEVEL, O_POWER_TRIM;
    logic [9:0] O_DIGITAL_GAIN;
    logic [3:0] O_ANALOG_GAIN;
    logic [7:0] O_FIRST_DAC_CODE, O_SECOND_DAC_CODE;
    int fails = 0;        // mismatches seen
    int comparisons = 0;  // checks made

    serial_host_model host (.o_sclk(I_SCLK), .o_serial_in(I_SERIAL_IN),
        .o_serial_latch_strobe(I_SERIAL_LATCH_STROBE));
    afe_serial_control_regs dut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_SCLK(I_SCLK),
        .I_SERIAL_IN(I_SERIAL_IN), .I_SERIAL_LATCH_STROBE(I_SERIAL_LATCH_STROBE),
        .I_REGISTER_COMMIT_STROBE(I_REGISTER_COMMIT_STROBE),
        .O_UPDATE_BY_STROBE(O_UPDATE_BY_STROBE), .O_COMMIT_ON_FALL(O_COMMIT_ON_FALL),
        .O_DUMMY_CLAMP_ACTIVE_HIGH(O_DUMMY_CLAMP_ACTIVE_HIGH),
        .O_BLACK_CLAMP_ACTIVE_HIGH(O_BLACK_CLAMP_ACTIVE_HIGH),
        .O_SAMPLE_ACTIVE_HIGH(O_SAMPLE_ACTIVE_HIGH), .O_STANDBY(O_STANDBY),
        .O_DAC1_STANDBY(O_DAC1_STANDBY), .O_DAC2_STANDBY(O_DAC2_STANDBY),
        .O_TEST_ENABLE(O_TEST_ENABLE), .O_OUTPUT_DELAY(O_OUTPUT_DELAY),
        .O_OUTPUT_HIZ(O_OUTPUT_HIZ), .O_SAMPLE_DELAY(O_SAMPLE_DELAY),
        .O_SAMPLE_DELAY_INVALID(O_SAMPLE_DELAY_INVALID), .O_CLAMP_CODE(O_CLAMP_CODE),
        .O_DEFECT_REJECT_LEVEL(O_DEFECT_REJECT_LEVEL), .O_DIGITAL_GAIN(O_DIGITAL_GAIN),
        .O_ANALOG_GAIN(O_ANALOG_GAIN), .O_POWER_TRIM(O_POWER_TRIM),
        .O_FIRST_DAC_CODE(O_FIRST_DAC_CODE), .O_SECOND_DAC_CODE(O_SECOND_DAC_CODE));

    // 25 MHz system clock
    always #20 I_CLK = ~I_CLK;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [61:0] exp, input logic [61:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one frame, then wait well past the 3..4 cycle update latency
    task automatic wr(input logic [9:0] a, input logic [47:0] g, input int n, input int t);
        @(posedge I_CLK);
        #1;
        host.send(a, g, n, t);
        repeat (8) @(posedge I_CLK);
        #1;
    endtask : wr
    // commit pin level change; commit lands 3 cycles later
    task automatic cm(input logic v);
        @(posedge I_CLK);
        #1;
        I_REGISTER_COMMIT_STROBE = v;
        repeat (6) @(posedge I_CLK);
        #1;
    endtask : cm
    task automatic do_reset;
        I_RESET = 1'b1;
        repeat (10) @(posedge I_CLK);
        #1;
        I_RESET = 1'b0;
        repeat (3) @(posedge I_CLK);
        #1;
    endtask : do_reset
    task automatic chk_defaults;
        chk("defaults", {9'b000000110, 2'h0, 1'b0, 2'h0, 1'b0, 5'h08, 6'h3f, 10'h0c0, 4'h0,
            6'h00, 8'h00, 8'h00}, {O_UPDATE_BY_STROBE, O_COMMIT_ON_FALL,
            O_DUMMY_CLAMP_ACTIVE_HIGH, O_BLACK_CLAMP_ACTIVE_HIGH, O_SAMPLE_ACTIVE_HIGH,
            O_STANDBY, O_DAC1_STANDBY, O_DAC2_STANDBY, O_TEST_ENABLE, O_OUTPUT_DELAY,
            O_OUTPUT_HIZ, O_SAMPLE_DELAY, O_SAMPLE_DELAY_INVALID, O_CLAMP_CODE,
            O_DEFECT_REJECT_LEVEL, O_DIGITAL_GAIN, O_ANALOG_GAIN, O_POWER_TRIM,
            O_FIRST_DAC_CODE, O_SECOND_DAC_CODE});
    endtask : chk_defaults
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // watchdog, far beyond the expected 15 us
    // ****************************************
    initial begin
        #400000;
        fails++;
        wrap_up();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        I_CLK = 1'b0;
        I_RESET = 1'b1;
        I_REGISTER_COMMIT_STROBE = 1'b0;
        do_reset();
        chk_defaults();
        wr(10'h001, 48'h3f, 1, 0);
        chk("stby", 4'hf, {O_STANDBY, O_DAC1_STANDBY, O_DAC2_STANDBY, O_TEST_ENABLE});
        wr(10'h001, 48'h00, 1, 0);
        chk("stby", 4'h0, {O_STANDBY, O_DAC1_STANDBY, O_DAC2_STANDBY, O_TEST_ENABLE});
        // run of three groups from address 2 plus an incomplete tail
        wr(10'h002, 48'({6'h1f, 6'h02, 6'h3b}), 3, 3);
        chk("odly", 3'b111, {O_OUTPUT_DELAY, O_OUTPUT_HIZ});
        chk("sdly", 3'b101, {O_SAMPLE_DELAY, O_SAMPLE_DELAY_INVALID});
        chk("clamp", 5'h1f, O_CLAMP_CODE);
        wr(10'h006, 48'({6'h01, 6'h07, 6'h3e, 6'h21, 6'h0c, 6'h33, 6'h2a, 6'h15}), 8, 5);
        chk("upper", {10'h295, 4'h3, 6'h0c, 8'ha1, 8'h47}, {O_DIGITAL_GAIN, O_ANALOG_GAIN,
            O_POWER_TRIM, O_FIRST_DAC_CODE, O_SECOND_DAC_CODE});
        // aliasing reserved address and a frame short of 16 bits
        wr(10'h204, 48'h00, 1, 0);
        wr(10'h003, 48'h00, 0, 4);
        chk("refuse", 7'h5f, {O_SAMPLE_DELAY, O_CLAMP_CODE});
        // buffered update on the rising commit edge
        wr(10'h000, 48'h3a, 1, 0);
        chk("pol", 5'b10111, {O_UPDATE_BY_STROBE, O_COMMIT_ON_FALL,
            O_DUMMY_CLAMP_ACTIVE_HIGH, O_BLACK_CLAMP_ACTIVE_HIGH, O_SAMPLE_ACTIVE_HIGH});
        wr(10'h005, 48'h15, 1, 0);
        wr(10'h009, 48'h2d, 1, 0);
        chk("held", 6'h3f, O_DEFECT_REJECT_LEVEL);
        chk("held_pwr", 6'h0c, O_POWER_TRIM);
        cm(1'b1);
        chk("commit", 6'h15, O_DEFECT_REJECT_LEVEL);
        chk("commit_pwr", 6'h2d, O_POWER_TRIM);
        wr(10'h000, 48'h04, 1, 0);
        cm(1'b0);
        chk("fall_ign", 2'b10, {O_UPDATE_BY_STROBE, O_COMMIT_ON_FALL});
        cm(1'b1);
        chk("pol2", 5'b01000, {O_UPDATE_BY_STROBE, O_COMMIT_ON_FALL,
            O_DUMMY_CLAMP_ACTIVE_HIGH, O_BLACK_CLAMP_ACTIVE_HIGH, O_SAMPLE_ACTIVE_HIGH});
        // falling edge selected: still gated although bit 1 is clear
        wr(10'h008, 48'h05, 1, 0);
        chk("gated", 4'h3, O_ANALOG_GAIN);
        cm(1'b0);
        chk("fall", 4'h5, O_ANALOG_GAIN);
        wr(10'h008, 48'h06, 1, 0);
        cm(1'b1);
        chk("rise_ign", 4'h5, O_ANALOG_GAIN);
        do_reset();
        chk_defaults();
        wrap_up();
    end
endmodule : tb
